// file: src/codec_control_regs_six_to_ten.sv
// register bank six to ten of the speech codec and synthesizer control port
// register map
// 0x6 mute, pattern routing, detector mode and gains, 16 bits
// 0x7 data path, pin functions, scrambler tap, synthesizer settings
// 0x8 outgoing code word
// 0x9 outgoing data word
// 0xa received data word, read only
//
// register port timing
// a strobe is taken at the rising edge where host_wr or host_rd is high
// a write shows on the outputs one cycle after its strobe
// a read answer stands on host_rdata until the next read
// host_rvalid marks the answer for exactly one cycle
// a write and a read in one cycle both act; the read sees old contents
// unmapped offsets take no write and read back as zero
//
// bit stream timing
// both pattern generators start at one and toggle on every strobe
// they run whether or not selected, so a switch lands mid-pattern
// scrambler_in and decoder_in hold until their next strobe
//
// reset
// nrst asserts at once; release passes two flip-flops first
// a host request is safe from the third edge after release
//
// limits
// receive gain codes above 18 are stored as 18
// bits 17..15 of register 7 are stored as written
// width parameters other than the defaults are refused
`timescale 1ns/1ns
module codec_control_regs_six_to_ten #(
   parameter int ADDR_BITS = codec_regs_pkg::ADDR_W,
   parameter int WORD_BITS = codec_regs_pkg::WORD_W
) (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [codec_regs_pkg::ADDR_W-1:0] host_addr,
   input wire logic [codec_regs_pkg::WORD_W-1:0] host_wdata,
   output logic [codec_regs_pkg::WORD_W-1:0] host_rdata,
   output logic host_rvalid,
   input wire logic rx_capture,
   input wire logic [codec_regs_pkg::WORD_W-1:0] rx_capture_word,
   input wire logic tx_bit_strobe,
   input wire logic encoder_bit,
   input wire logic rx_bit_strobe,
   input wire logic rx_stream_bit,
   input wire logic idle_detect,
   output codec_regs_pkg::mute_gain_s mute_gain,
   output codec_regs_pkg::datapath_s datapath,
   output logic [codec_regs_pkg::WORD_W-1:0] tx_code_word,
   output logic [codec_regs_pkg::WORD_W-1:0] tx_data_word,
   output logic scrambler_in,
   output logic decoder_in,
   output logic idle_force,
   output logic idle_status
);
   import codec_regs_pkg::*;

   // parameters that the fixed layout cannot serve
   generate
      if (ADDR_BITS != ADDR_W || WORD_BITS != WORD_W) begin : g_bad_width
         $error("codec register bank supports only 4-bit address, 24-bit word");
      end
   endgenerate

   // keeps receive gain inside its 19 usable codes
   // codes above the top step select no defined gain
   function automatic logic [4:0] clamp_gain(input logic [4:0] code);
      clamp_gain = (code > RX_GAIN_MAX) ? RX_GAIN_MAX : code;
   endfunction

   // next bit of an alternating 1010 generator
   function automatic logic pattern_step(input logic strobe, input logic cur);
      pattern_step = strobe ? ~cur : cur;
   endfunction

   // reset release through two flip-flops
   // the first flip-flop is read only by the second
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_meta_reg <= 1'h0;
         rst_sync_reg <= 1'h0;
      end else begin
         rst_meta_reg <= 1'h1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   logic rst_n;
   assign rst_n = rst_sync_reg;

   // register 6
   mute_gain_s mute_gain_reg;
   mute_gain_s mute_gain_next;

   // register 7
   datapath_s datapath_reg;
   datapath_s datapath_next;

   // registers 8 and 9
   logic [WORD_W-1:0] code_word_reg;
   logic [WORD_W-1:0] code_word_next;
   logic [WORD_W-1:0] data_word_reg;
   logic [WORD_W-1:0] data_word_next;

   // register 10, written only by the receive capture
   logic [WORD_W-1:0] rx_word_reg;
   logic [WORD_W-1:0] rx_word_next;

   // read answer
   logic [WORD_W-1:0] rdata_reg;
   logic [WORD_W-1:0] rdata_next;
   logic rvalid_reg;
   logic rvalid_next;

   // host writes and receive word capture
   always_comb begin
      // every register keeps its value unless written
      mute_gain_next = mute_gain_reg;
      datapath_next = datapath_reg;
      code_word_next = code_word_reg;
      data_word_next = data_word_reg;
      rx_word_next = rx_word_reg;
      if (host_wr) begin
         case (host_addr)
            OFF_MUTE_ROUTING_GAIN: begin
               mute_gain_next = host_wdata[MG_W-1:0];
               mute_gain_next.rx_audio_gain =
                  clamp_gain(host_wdata[10:6]);
            end
            OFF_DATAPATH_PLL_CONFIG: begin
               datapath_next = host_wdata;
            end
            OFF_TX_CODE_WORD: begin
               code_word_next = host_wdata;
            end
            OFF_TX_DATA_WORD: begin
               data_word_next = host_wdata;
            end
            default: begin
               // receive word and unmapped offsets take no write
               mute_gain_next = mute_gain_reg;
            end
         endcase
      end
      // only the receive capture loads register 10
      if (rx_capture) begin
         rx_word_next = rx_capture_word;
      end
   end

   // read answers, one cycle after the strobe
   always_comb begin
      // the mux reads state from before any same-cycle write
      rdata_next = rdata_reg;
      rvalid_next = host_rd;
      if (host_rd) begin
         case (host_addr)
            OFF_MUTE_ROUTING_GAIN: begin
               rdata_next = {8'h00, mute_gain_reg};
            end
            OFF_DATAPATH_PLL_CONFIG: begin
               rdata_next = datapath_reg;
            end
            OFF_TX_CODE_WORD: begin
               rdata_next = code_word_reg;
            end
            OFF_TX_DATA_WORD: begin
               rdata_next = data_word_reg;
            end
            OFF_RX_DATA_WORD: begin
               rdata_next = rx_word_reg;
            end
            default: begin
               rdata_next = WORD_RESET;
            end
         endcase
      end
   end

   // register bank flip-flops, power-up values in reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         mute_gain_reg <= MUTE_ROUTING_GAIN_RESET;
         datapath_reg <= DATAPATH_PLL_CONFIG_RESET;
         code_word_reg <= WORD_RESET;
         data_word_reg <= WORD_RESET;
         rx_word_reg <= WORD_RESET;
         rdata_reg <= WORD_RESET;
         rvalid_reg <= 1'h0;
      end else begin
         mute_gain_reg <= mute_gain_next;
         datapath_reg <= datapath_next;
         code_word_reg <= code_word_next;
         data_word_reg <= data_word_next;
         rx_word_reg <= rx_word_next;
         rdata_reg <= rdata_next;
         rvalid_reg <= rvalid_next;
      end
   end

   // bit routing state: pattern generators and selected streams
   // alternating generators
   logic tx_pat_reg;
   logic tx_pat_next;
   logic rx_pat_reg;
   logic rx_pat_next;

   // selected streams
   logic scr_in_reg;
   logic scr_in_next;
   logic dec_in_reg;
   logic dec_in_next;

   // idle outputs
   logic idle_force_reg;
   logic idle_force_next;
   logic idle_status_reg;
   logic idle_status_next;

   // pattern select, idle action gating
   always_comb begin
      tx_pat_next = pattern_step(tx_bit_strobe, tx_pat_reg);
      rx_pat_next = pattern_step(rx_bit_strobe, rx_pat_reg);
      scr_in_next = scr_in_reg;
      dec_in_next = dec_in_reg;
      if (tx_bit_strobe) begin
         scr_in_next = mute_gain_reg.tx_pattern_sel ? tx_pat_reg
                                                    : encoder_bit;
      end
      if (rx_bit_strobe) begin
         dec_in_next = mute_gain_reg.rx_pattern_sel ? rx_pat_reg
                                                    : rx_stream_bit;
      end
      idle_force_next = idle_detect & ~datapath_reg.idle_auto_off;
      idle_status_next = idle_detect;
   end

   // routing flip-flops, generators start at one
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_pat_reg <= PATTERN_FIRST;
         rx_pat_reg <= PATTERN_FIRST;
         scr_in_reg <= 1'h0;
         dec_in_reg <= 1'h0;
         idle_force_reg <= 1'h0;
         idle_status_reg <= 1'h0;
      end else begin
         tx_pat_reg <= tx_pat_next;
         rx_pat_reg <= rx_pat_next;
         scr_in_reg <= scr_in_next;
         dec_in_reg <= dec_in_next;
         idle_force_reg <= idle_force_next;
         idle_status_reg <= idle_status_next;
      end
   end

   // outputs straight from the registers
   // register port answers
   assign host_rdata = rdata_reg;
   assign host_rvalid = rvalid_reg;

   // register contents
   assign mute_gain = mute_gain_reg;
   assign datapath = datapath_reg;
   assign tx_code_word = code_word_reg;
   assign tx_data_word = data_word_reg;

   // bit streams and idle
   assign scrambler_in = scr_in_reg;
   assign decoder_in = dec_in_reg;
   assign idle_force = idle_force_reg;
   assign idle_status = idle_status_reg;
endmodule

// file: src/codec_regs_pkg.sv
// constants and field layouts for the codec control registers six to ten
package codec_regs_pkg;
   localparam int ADDR_W = 4;
   localparam int WORD_W = 24;
   localparam int MG_W = 16;
   // register offsets
   localparam logic [ADDR_W-1:0] OFF_MUTE_ROUTING_GAIN = 4'h6;
   localparam logic [ADDR_W-1:0] OFF_DATAPATH_PLL_CONFIG = 4'h7;
   localparam logic [ADDR_W-1:0] OFF_TX_CODE_WORD = 4'h8;
   localparam logic [ADDR_W-1:0] OFF_TX_DATA_WORD = 4'h9;
   localparam logic [ADDR_W-1:0] OFF_RX_DATA_WORD = 4'ha;
   // power-up values
   localparam logic [MG_W-1:0] MUTE_ROUTING_GAIN_RESET = 16'h23c0;
   localparam logic [WORD_W-1:0] DATAPATH_PLL_CONFIG_RESET = 24'h001a00;
   localparam logic [WORD_W-1:0] WORD_RESET = 24'h000000;
   // receive gain: 19 steps, codes 0 to 18
   localparam logic [4:0] RX_GAIN_MAX = 5'h12;
   // first bit sent by each alternating pattern generator
   localparam logic PATTERN_FIRST = 1'h1;
   // mute, routing, detector mode and gains (bit 15 down to bit 0)
   typedef struct packed {
      logic [4:0] tx_remote_gain;
      logic [4:0] rx_audio_gain;
      logic carrier_detect_mode;
      logic tx_pattern_sel;
      logic rx_pattern_sel;
      logic tx_speech_mute;
      logic rx_speech_mute;
      logic amp_mute;
   } mute_gain_s;
   // data path, pin function and synthesizer settings (bit 23 down to 0)
   typedef struct packed {
      logic tx_cp_invert;
      logic rx_cp_invert;
      logic second_local_oscillator_cp_invert;
      logic [2:0] second_local_oscillator_tune_cap;
      logic [2:0] test_mode;
      logic charge_comp_off;
      logic modulus_rail_out;
      logic data_word_24;
      logic code_word_24;
      logic [2:0] scrambler_tap;
      logic [1:0] multipurpose_pin_two_sel;
      logic [1:0] multipurpose_pin_one_sel;
      logic detect_bypass;
      logic idle_auto_off;
      logic scrambler_bypass;
      logic clock_recovery_bypass;
   } datapath_s;
endpackage

// file: test/codec_regs_chk.sv
// assertions and covers for the codec control register bank
`timescale 1ns/1ns
module codec_regs_chk import codec_regs_pkg::*; (
   input wire logic core_clk,
   input wire logic nrst,
   input wire logic host_wr,
   input wire logic host_rd,
   input wire logic [ADDR_W-1:0] host_addr,
   input wire logic [WORD_W-1:0] host_wdata,
   input wire logic [WORD_W-1:0] host_rdata,
   input wire logic rx_capture,
   input wire logic [WORD_W-1:0] rx_capture_word,
   input wire logic tx_bit_strobe,
   input wire logic encoder_bit,
   input wire logic rx_bit_strobe,
   input wire logic idle_detect,
   input wire mute_gain_s mute_gain,
   input wire datapath_s datapath,
   input wire logic [WORD_W-1:0] tx_code_word,
   input wire logic [WORD_W-1:0] tx_data_word,
   input wire logic scrambler_in,
   input wire logic decoder_in,
   input wire logic idle_force,
   input wire logic idle_status
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // register writes land one cycle later
   a_mute_write: assert property (host_wr && host_addr == OFF_MUTE_ROUTING_GAIN &&
      host_wdata[10:6] <= RX_GAIN_MAX |=> mute_gain == $past(host_wdata[15:0]))
      else $error("mute gain write");
   a_gain_clamp: assert property (host_wr && host_addr == OFF_MUTE_ROUTING_GAIN &&
      host_wdata[10:6] > RX_GAIN_MAX |=> mute_gain.rx_audio_gain == RX_GAIN_MAX)
      else $error("gain clamp");
   a_cfg_write: assert property (host_wr && host_addr == OFF_DATAPATH_PLL_CONFIG
      |=> datapath == $past(host_wdata)) else $error("config write");
   a_code_write: assert property (host_wr && host_addr == OFF_TX_CODE_WORD
      |=> tx_code_word == $past(host_wdata)) else $error("code word write");
   a_data_write: assert property (host_wr && host_addr == OFF_TX_DATA_WORD
      |=> tx_data_word == $past(host_wdata)) else $error("data word write");
   // captured word read back
   a_rx_readback: assert property (rx_capture ##1 host_rd && !rx_capture &&
      host_addr == OFF_RX_DATA_WORD |=> host_rdata == $past(rx_capture_word, 2))
      else $error("rx word read");
   // bit stream routing
   a_tx_path: assert property (tx_bit_strobe && !mute_gain.tx_pattern_sel
      |=> scrambler_in == $past(encoder_bit)) else $error("scrambler source");
   a_rx_toggle: assert property (rx_bit_strobe && mute_gain.rx_pattern_sel &&
      $past(rx_bit_strobe) && $past(mute_gain.rx_pattern_sel)
      |=> decoder_in != $past(decoder_in)) else $error("rx pattern");
   a_idle_paths: assert property (idle_detect |=> idle_status &&
      idle_force == !$past(datapath.idle_auto_off)) else $error("idle outputs");
   // main scenarios reached
   c_cfg: cover property (host_wr && host_addr == OFF_DATAPATH_PLL_CONFIG);
   c_rx: cover property (rx_capture ##1 host_rd);
   c_idle: cover property (idle_detect && datapath.idle_auto_off);
endmodule
bind codec_control_regs_six_to_ten codec_regs_chk chk (.*);

// file: test/host_port_model.sv
// host microcontroller model on the register strobe port
`timescale 1ns/1ns
module host_port_model import codec_regs_pkg::*; (
   input wire logic core_clk,
   input wire logic [WORD_W-1:0] host_rdata,
   input wire logic host_rvalid,
   output logic host_wr,
   output logic host_rd,
   output logic [ADDR_W-1:0] host_addr,
   output logic [WORD_W-1:0] host_wdata
);
   // idle port at time zero
   initial begin
      host_wr = 1'h0;
      host_rd = 1'h0;
      host_addr = 4'h0;
      host_wdata = 24'h000000;
   end
   // one strobe cycle, answer taken while rvalid stands
   task automatic xfer(input logic w, input logic r, input logic [ADDR_W-1:0] a,
         input logic [WORD_W-1:0] d, output logic [WORD_W-1:0] q);
      @(posedge core_clk);
      host_wr <= w;
      host_rd <= r;
      host_addr <= a;
      host_wdata <= (a == OFF_DATAPATH_PLL_CONFIG) ? (d & 24'hfc7fff) : d;
      @(posedge core_clk);
      host_wr <= 1'h0;
      host_rd <= 1'h0;
      host_addr <= ~a;
      host_wdata <= ~d;
      @(posedge core_clk);
      q = host_rvalid ? host_rdata : 24'hxxxxxx;
   endtask
endmodule

// file: test/test_codec_control_regs_six_to_ten.sv
// self-checking bench for the codec control register bank
`timescale 1ns/1ns
module test_codec_control_regs_six_to_ten;
   import codec_regs_pkg::*;
   typedef struct packed {
      logic w;
      logic [ADDR_W-1:0] a;
      logic [WORD_W-1:0] d;
      logic [WORD_W-1:0] e;
   } row_s;
   logic core_clk, nrst, host_wr, host_rd, host_rvalid, rx_capture, tx_bit_strobe;
   logic encoder_bit, rx_bit_strobe, rx_stream_bit, idle_detect, scrambler_in, decoder_in;
   logic idle_force, idle_status;
   logic [ADDR_W-1:0] host_addr;
   logic [WORD_W-1:0] host_wdata, host_rdata, rx_capture_word, tx_code_word, tx_data_word, q;
   mute_gain_s mute_gain;
   datapath_s datapath;
   int miscompares = 0;
   int checks_done = 0;
   row_s rows [11] = '{'{1'h0, 4'h6, 24'h0, 24'h0023c0}, '{1'h0, 4'h7, 24'h0, 24'h001a00},
      '{1'h0, 4'h8, 24'h0, 24'h0}, '{1'h0, 4'ha, 24'h0, 24'h0},
      '{1'h1, 4'h6, 24'hffffff, 24'h00fcbf}, '{1'h1, 4'h6, 24'hff1235, 24'h001235},
      '{1'h1, 4'h7, 24'he407ff, 24'he407ff}, '{1'h1, 4'h8, 24'ha5a5a5, 24'ha5a5a5},
      '{1'h1, 4'h9, 24'h5a5a5a, 24'h5a5a5a}, '{1'h1, 4'h3, 24'h123456, 24'h0},
      '{1'h0, 4'h7, 24'h0, 24'he407ff}};
   codec_control_regs_six_to_ten DUT (.*);
   host_port_model host (.*);
   task automatic chk(input logic [WORD_W-1:0] seen, input logic [WORD_W-1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // clock
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   // watchdog
   initial begin
      #200000;
      miscompares++;
      summarize;
   end
   // main sequence
   initial begin
      nrst = 1'h0;
      rx_capture = 1'h0;
      rx_capture_word = 24'h0;
      tx_bit_strobe = 1'h0;
      rx_bit_strobe = 1'h0;
      encoder_bit = 1'h0;
      rx_stream_bit = 1'h0;
      idle_detect = 1'h0;
      repeat (6) @(posedge core_clk);
      nrst <= 1'h1;
      repeat (3) @(posedge core_clk);
      foreach (rows[i]) begin
         if (rows[i].w) host.xfer(1'h1, 1'h0, rows[i].a, rows[i].d, q);
         host.xfer(1'h0, 1'h1, rows[i].a, 24'h0, q);
         chk(q, rows[i].e);
      end
      chk({8'h00, mute_gain}, 24'h001235);
      chk(tx_code_word, 24'ha5a5a5);
      chk(tx_data_word, 24'h5a5a5a);
      // capture, then read and write the receive word together
      @(posedge core_clk);
      rx_capture <= 1'h1;
      rx_capture_word <= 24'h3c5a96;
      fork
         host.xfer(1'h1, 1'h1, OFF_RX_DATA_WORD, 24'hffffff, q);
         begin
            @(posedge core_clk);
            rx_capture <= 1'h0;
         end
      join
      chk(q, 24'h3c5a96);
      host.xfer(1'h0, 1'h1, OFF_RX_DATA_WORD, 24'h0, q);
      chk(q, 24'h3c5a96);
      // both pattern generators on, streams low
      host.xfer(1'h1, 1'h0, OFF_MUTE_ROUTING_GAIN, 24'h000018, q);
      tx_bit_strobe <= 1'h1;
      rx_bit_strobe <= 1'h1;
      repeat (2) @(posedge core_clk);
      #1;
      q[1:0] = {scrambler_in, decoder_in};
      @(posedge core_clk);
      #1;
      chk({22'h0, scrambler_in, decoder_in}, {22'h0, ~q[1:0]});
      encoder_bit <= 1'h1;
      rx_stream_bit <= 1'h1;
      host.xfer(1'h1, 1'h0, OFF_MUTE_ROUTING_GAIN, 24'h000000, q);
      #1;
      chk({22'h0, scrambler_in, decoder_in}, 24'h000003);
      tx_bit_strobe <= 1'h0;
      rx_bit_strobe <= 1'h0;
      // idle action off, then on
      idle_detect <= 1'h1;
      host.xfer(1'h1, 1'h0, OFF_DATAPATH_PLL_CONFIG, 24'h000004, q);
      #1;
      chk({22'h0, idle_force, idle_status}, 24'h000001);
      host.xfer(1'h1, 1'h0, OFF_DATAPATH_PLL_CONFIG, 24'h000000, q);
      #1;
      chk({22'h0, idle_force, idle_status}, 24'h000003);
      idle_detect <= 1'h0;
      // second reset in mid-run
      @(posedge core_clk);
      #1;
      nrst <= 1'h0;
      #1;
      chk(datapath, 24'h001a00);
      chk(tx_code_word, 24'h000000);
      repeat (2) @(posedge core_clk);
      nrst <= 1'h1;
      repeat (3) @(posedge core_clk);
      host.xfer(1'h0, 1'h1, OFF_RX_DATA_WORD, 24'h0, q);
      chk(q, 24'h000000);
      summarize;
   end
endmodule
